//--- core/cmrt_cfg.svh
// constants of the counter mode routing and totalize block
`ifndef CMRT_CFG_SVH
`define CMRT_CFG_SVH
`define CMRT_CLK_MHZ 100
`define CMRT_CLK_PERIOD_NS (1000 / `CMRT_CLK_MHZ)
`define CMRT_ADDR_CTRL 8'h00
`define CMRT_ADDR_AVG 8'h04
`define CMRT_ADDR_GATE 8'h08
`define CMRT_ADDR_STAT 8'h0C
`define CMRT_ADDR_DISP 8'h10
`define CMRT_ADDR_ACCUM 8'h14
`define CMRT_CTRL_FUNC_LSB 0
`define CMRT_CTRL_FUNC_MSB 2
`define CMRT_CTRL_HOLD_BIT 4
`define CMRT_CTRL_CLR_BIT 5
`define CMRT_CTRL_LOCKOUT_BIT 6
`define CMRT_STAT_BLANK_BIT 0
`define CMRT_STAT_BUSY_BIT 1
`define CMRT_STAT_LOCK_BIT 2
`define CMRT_STAT_ARMED_BIT 3
`define CMRT_STAT_ROUTE_LSB 4
`define CMRT_STAT_ROUTE_MSB 7
`define CMRT_STAT_DP_BIT 8
`define CMRT_AVG_MAX 10'h3E8
`define CMRT_AVG_MIN 10'h001
`define CMRT_GATE_RST 32'h000F4240
`define CMRT_DIV_RATIO 4'hA
`define CMRT_DIV_HALF 4'h5
`define CMRT_MULT_FACTOR 32'h00000064
`define CMRT_MULT_MIN_PERIOD_NS 40000
`define CMRT_MULT_MAX_PERIOD_NS 100000000
`define CMRT_MULT_MIN_PERIOD_CYC \
  ((`CMRT_MULT_MIN_PERIOD_NS + `CMRT_CLK_PERIOD_NS - 1) / `CMRT_CLK_PERIOD_NS)
`define CMRT_MULT_MAX_PERIOD_CYC (`CMRT_MULT_MAX_PERIOD_NS / `CMRT_CLK_PERIOD_NS)
`define CMRT_RESP_OKAY 2'h0
`define CMRT_RESP_SLVERR 2'h2
`endif

//--- core/cmrt_pkg.sv
// types of the counter mode routing and totalize block
package cmrt_pkg;
  typedef enum logic [2:0] {
    func_freq_low, func_freq_high, func_period, func_width_pos, func_width_neg, func_totalize
  } cmrt_func_t;
  typedef enum logic [1:0] {w_arm, w_ready, w_meas} cmrt_wstate_t;
  typedef struct packed {
    logic direct_en;
    logic alt_en;
    logic presc_en_n;
    logic mult_en;
  } cmrt_route_t;
  typedef struct packed {
    cmrt_func_t func;
    logic hold;
    logic clr;
    logic lockout;
  } cmrt_ctrl_t;
endpackage

//--- core/cmrt_prescale.sv
// divide-by-ten prescaler on the conditioned input
`timescale 1ns/10ps
`include "cmrt_cfg.svh"
module cmrt_prescale (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic en_n,
  input wire logic sig,
  output logic div_q
);
  logic [3:0] cnt_q;
  logic prev_q;
  logic [3:0] cnt_nx;

  assign cnt_nx = (cnt_q == `CMRT_DIV_RATIO - 4'h1) ? 4'h0 : cnt_q + 4'h1;

  // edge history runs even while disabled so enabling never fakes an edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= sig;
    end
  end

  // output high for five input edges, low for five: one rise per ten
  always_ff @(posedge aclk) begin
    if (!aresetn || en_n) begin
      // parked on the last count so the first period after enable is ten edges long
      cnt_q <= `CMRT_DIV_RATIO - 4'h1;
      div_q <= 1'b0;
    end else if (sig && !prev_q) begin
      cnt_q <= cnt_nx;
      div_q <= (cnt_nx < `CMRT_DIV_HALF);
    end
  end
endmodule // cmrt_prescale

//--- core/cmrt_mult.sv
// times-hundred resolution multiplier, digital stand-in for the loop
`timescale 1ns/10ps
`include "cmrt_cfg.svh"
module cmrt_mult #(
  parameter int unsigned MAX_PERIOD_CYC = `CMRT_MULT_MAX_PERIOD_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic en,
  input wire logic sig_rise,
  output logic pulse_q,
  output logic in_range_q,
  output logic locked_q
);
  localparam logic [31:0] MinCyc = 32'(`CMRT_MULT_MIN_PERIOD_CYC);
  localparam logic [31:0] MaxCyc = 32'(MAX_PERIOD_CYC);
  logic [31:0] per_cnt_q;
  logic [31:0] period_q;
  logic [31:0] acc_q;
  logic [31:0] acc_nx;

  // input period in clocks; a stalled input falls out of range
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_cnt_q <= 32'h0;
      period_q <= 32'h0;
      in_range_q <= 1'b0;
    end else if (sig_rise) begin
      per_cnt_q <= 32'h0;
      period_q <= per_cnt_q + 32'h1;
      in_range_q <= (per_cnt_q + 32'h1 >= MinCyc) && (per_cnt_q + 32'h1 <= MaxCyc);
    end else if (per_cnt_q <= MaxCyc) begin
      per_cnt_q <= per_cnt_q + 32'h1;
    end else begin
      in_range_q <= 1'b0;
    end
  end

  assign acc_nx = acc_q + `CMRT_MULT_FACTOR;

  // hundred evenly spread pulses per measured input period
  always_ff @(posedge aclk) begin
    if (!aresetn || !en || !in_range_q) begin
      acc_q <= 32'h0;
      pulse_q <= 1'b0;
    end else if (acc_nx >= period_q) begin
      acc_q <= acc_nx - period_q;
      pulse_q <= 1'b1;
    end else begin
      acc_q <= acc_nx;
      pulse_q <= 1'b0;
    end
  end

  // lock shown only while the path is in use and the input is in range
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      locked_q <= 1'b0;
    end else begin
      locked_q <= en && in_range_q;
    end
  end
endmodule // cmrt_mult

//--- core/cmrt_top.sv
// counter input routing, width averaging, totalize and register slave
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
`include "cmrt_cfg.svh"
// Contract
// - width averaging over a chosen event count, at most 1000 per result
// - width modes arm on a first pulse, then measure the next pulses
// - totalize counts every event, total kept until reset or function change
// - totalize result is a whole number with no decimal point
// - in totalize only reset and freeze affect the display, averaging ignored
// - freeze in totalize holds only the display, the total keeps counting
// - freeze release loads the display from the total, then it follows
// - input reaches the counter over exactly one of four paths
// - negative width uses the alternate direct path instead of the normal one
// - above 10 MHz both direct paths are off, only the prescaler feeds
// - prescaler gives one output edge per ten input edges
// - prescaler enable is active low, only in high band frequency function
// - low band inputs from 10 Hz to 25 kHz go through the multiplier
// - routed signal drives event inputs A and B together
// - positive width starts on A rising and stops on B falling
// - reset clears the counter and blanks the display
// - freeze outside totalize stops counting and keeps the last result
module cmrt_top #(
  parameter int unsigned MULT_MAX_PERIOD_CYC = `CMRT_MULT_MAX_PERIOD_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sig_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output cmrt_pkg::cmrt_route_t route_q,
  output logic event_a_q,
  output logic event_b_q,
  output logic [31:0] display_q,
  output logic display_blank_q,
  output logic display_point_en_q,
  output logic gate_busy_q,
  output logic mult_lock_q
);
  // merge write strobes into a stored word
  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // one-hot path choice from function and input range
  function automatic cmrt_pkg::cmrt_route_t route_of(input cmrt_pkg::cmrt_func_t f,
                                                     input logic mult_ok);
    cmrt_pkg::cmrt_route_t r;
    r = '{direct_en: 1'b1, alt_en: 1'b0, presc_en_n: 1'b1, mult_en: 1'b0};
    case (f)
      cmrt_pkg::func_width_neg: begin
        r.direct_en = 1'b0;
        r.alt_en = 1'b1;
      end
      cmrt_pkg::func_freq_high: begin
        r.direct_en = 1'b0;
        r.presc_en_n = 1'b0;
      end
      cmrt_pkg::func_freq_low: begin
        if (mult_ok) begin
          r.direct_en = 1'b0;
          r.mult_en = 1'b1;
        end
      end
      default: begin
      end
    endcase
    return r;
  endfunction

  cmrt_pkg::cmrt_ctrl_t ctrl_q;
  cmrt_pkg::cmrt_func_t func_prev_q;
  cmrt_pkg::cmrt_wstate_t wst_q;
  logic [9:0] avg_q;
  logic [31:0] gate_q;
  logic [31:0] count_q;
  logic [31:0] count_inc;
  logic [31:0] gate_cnt_q;
  logic [9:0] ev_cnt_q;
  logic sig_s1_q, sig_s2_q, sig_s3_q, sig_q, sig_prev_q;
  logic a_prev_q, b_prev_q, a_rise, b_fall, routed, func_chg, tot;
  logic presc_out, mult_pulse, mult_in_range, mult_locked;
  logic aw_have_q, w_have_q, ar_have_q, do_write;
  logic aw_have_d, w_have_d, ar_have_d, bvalid_d, rvalid_d;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [31:0] ctrl_word;
  logic [31:0] avg_word;

  // three stages; a change counts once the last two agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sig_s1_q <= 1'b0;
      sig_s2_q <= 1'b0;
      sig_s3_q <= 1'b0;
      sig_q <= 1'b0;
      sig_prev_q <= 1'b0;
    end else begin
      sig_s1_q <= sig_in;
      sig_s2_q <= sig_s1_q;
      sig_s3_q <= sig_s2_q;
      sig_q <= (sig_s2_q == sig_s3_q) ? sig_s3_q : sig_q;
      sig_prev_q <= sig_q;
    end
  end

  cmrt_prescale u_presc (
    .aclk(aclk),
    .aresetn(aresetn),
    .en_n(route_q.presc_en_n),
    .sig(sig_q),
    .div_q(presc_out)
  );

  cmrt_mult #(
    .MAX_PERIOD_CYC(MULT_MAX_PERIOD_CYC)
  ) u_mult (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(route_q.mult_en),
    .sig_rise(sig_q && !sig_prev_q),
    .pulse_q(mult_pulse),
    .in_range_q(mult_in_range),
    .locked_q(mult_locked)
  );

  // registered path enables, decoded from function, multiplier range and lockout, always one-hot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_q <= '{direct_en: 1'b1, alt_en: 1'b0, presc_en_n: 1'b1, mult_en: 1'b0};
      mult_lock_q <= 1'b0;
    end else begin
      route_q <= route_of(ctrl_q.func, mult_in_range && !ctrl_q.lockout);
      mult_lock_q <= mult_locked;
    end
  end

  // the one enabled path feeds the counting core
  always_comb begin
    routed = 1'b0;
    case (1'b1)
      route_q.direct_en: routed = sig_q;
      route_q.alt_en: routed = !sig_q;
      !route_q.presc_en_n: routed = presc_out;
      route_q.mult_en: routed = mult_pulse;
      default: routed = 1'b0;
    endcase
  end

  // both event inputs see the same routed signal
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_a_q <= 1'b0;
      event_b_q <= 1'b0;
      a_prev_q <= 1'b0;
      b_prev_q <= 1'b0;
    end else begin
      event_a_q <= routed;
      event_b_q <= routed;
      a_prev_q <= event_a_q;
      b_prev_q <= event_b_q;
    end
  end

  assign a_rise = event_a_q && !a_prev_q;
  assign b_fall = !event_b_q && b_prev_q;
  assign func_chg = (ctrl_q.func != func_prev_q);
  assign tot = (ctrl_q.func == cmrt_pkg::func_totalize);
  assign count_inc = count_q + {31'h0, a_rise};

  // function history, a change restarts the measurement
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      func_prev_q <= cmrt_pkg::func_freq_low;
      display_point_en_q <= 1'b1;
    end else begin
      func_prev_q <= ctrl_q.func;
      display_point_en_q <= !tot;
    end
  end

  // counting core; hold freezes all but the totalize accumulator and the busy flag, which it clears outside totalize
  always_ff @(posedge aclk) begin
    if (!aresetn || ctrl_q.clr || func_chg) begin
      count_q <= 32'h0;
      gate_cnt_q <= 32'h0;
      ev_cnt_q <= 10'h0;
      wst_q <= cmrt_pkg::w_arm;
      display_q <= 32'h0;
      display_blank_q <= 1'b1;
      gate_busy_q <= 1'b0;
    end else if (tot) begin
      count_q <= count_inc;
      gate_busy_q <= 1'b1;
      if (!ctrl_q.hold) begin
        display_q <= count_inc;
        display_blank_q <= 1'b0;
      end
    end else if (ctrl_q.hold) begin
      gate_busy_q <= 1'b0;
    end else begin
      case (ctrl_q.func)
        cmrt_pkg::func_period: begin
          gate_busy_q <= (wst_q == cmrt_pkg::w_meas);
          if (wst_q != cmrt_pkg::w_meas) begin
            if (a_rise) begin
              wst_q <= cmrt_pkg::w_meas;
              count_q <= 32'h0;
              ev_cnt_q <= 10'h0;
            end
          end else if (a_rise && (ev_cnt_q + 10'h1 >= avg_q)) begin
            display_q <= count_q + 32'h1;
            display_blank_q <= 1'b0;
            count_q <= 32'h0;
            ev_cnt_q <= 10'h0;
          end else begin
            count_q <= count_q + 32'h1;
            ev_cnt_q <= ev_cnt_q + {9'h0, a_rise};
          end
        end
        cmrt_pkg::func_width_pos, cmrt_pkg::func_width_neg: begin
          gate_busy_q <= (wst_q != cmrt_pkg::w_arm);
          case (wst_q)
            cmrt_pkg::w_arm: begin
              if (b_fall) begin
                wst_q <= cmrt_pkg::w_ready;
              end
            end
            cmrt_pkg::w_ready: begin
              if (a_rise) begin
                wst_q <= cmrt_pkg::w_meas;
              end
            end
            cmrt_pkg::w_meas: begin
              if (b_fall) begin
                wst_q <= cmrt_pkg::w_ready;
                if (ev_cnt_q + 10'h1 >= avg_q) begin
                  display_q <= count_q + 32'h1;
                  display_blank_q <= 1'b0;
                  count_q <= 32'h0;
                  ev_cnt_q <= 10'h0;
                end else begin
                  count_q <= count_q + 32'h1;
                  ev_cnt_q <= ev_cnt_q + 10'h1;
                end
              end else begin
                count_q <= count_q + 32'h1;
              end
            end
            default: wst_q <= cmrt_pkg::w_arm;
          endcase
        end
        default: begin
          // frequency: events counted over a gate of programmed clocks
          gate_busy_q <= 1'b1;
          if (gate_cnt_q + 32'h1 >= gate_q) begin
            display_q <= count_inc;
            display_blank_q <= 1'b0;
            count_q <= 32'h0;
            gate_cnt_q <= 32'h0;
          end else begin
            count_q <= count_inc;
            gate_cnt_q <= gate_cnt_q + 32'h1;
          end
        end
      endcase
    end
  end

  // write channel bookkeeping; address and data may come in either order
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  assign aw_have_d = (s_axi_awvalid && s_axi_awready) || (aw_have_q && !do_write);
  assign w_have_d = (s_axi_wvalid && s_axi_wready) || (w_have_q && !do_write);
  assign bvalid_d = do_write || (s_axi_bvalid && !s_axi_bready);
  assign ar_have_d = s_axi_arvalid && s_axi_arready;
  assign rvalid_d = ar_have_q || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CMRT_RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      s_axi_awready <= !aw_have_d && !bvalid_d;
      s_axi_wready <= !w_have_d && !bvalid_d;
      s_axi_bvalid <= bvalid_d;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bresp <= (awaddr_q <= `CMRT_ADDR_ACCUM && awaddr_q[1:0] == 2'h0) ?
                       `CMRT_RESP_OKAY : `CMRT_RESP_SLVERR;
      end
    end
  end

  // written words merged with current settings before clamping
  assign ctrl_word = apply_strb({25'h0, ctrl_q.lockout, ctrl_q.clr, ctrl_q.hold, 1'b0,
                                 ctrl_q.func}, wdata_q, wstrb_q);
  assign avg_word = apply_strb({22'h0, avg_q}, wdata_q, wstrb_q);

  // software settings; averaging clamped to one through a thousand
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '{func: cmrt_pkg::func_freq_low, hold: 1'b0, clr: 1'b0, lockout: 1'b0};
      avg_q <= `CMRT_AVG_MIN;
      gate_q <= `CMRT_GATE_RST;
    end else if (do_write) begin
      case (awaddr_q)
        `CMRT_ADDR_CTRL: begin
          ctrl_q.func <= cmrt_pkg::cmrt_func_t'(ctrl_word[`CMRT_CTRL_FUNC_MSB:`CMRT_CTRL_FUNC_LSB]);
          ctrl_q.hold <= ctrl_word[`CMRT_CTRL_HOLD_BIT];
          ctrl_q.clr <= ctrl_word[`CMRT_CTRL_CLR_BIT];
          ctrl_q.lockout <= ctrl_word[`CMRT_CTRL_LOCKOUT_BIT];
        end
        `CMRT_ADDR_AVG: begin
          if (avg_word > {22'h0, `CMRT_AVG_MAX}) begin
            avg_q <= `CMRT_AVG_MAX;
          end else if (avg_word == 32'h0) begin
            avg_q <= `CMRT_AVG_MIN;
          end else begin
            avg_q <= avg_word[9:0];
          end
        end
        `CMRT_ADDR_GATE: begin
          gate_q <= (apply_strb(gate_q, wdata_q, wstrb_q) == 32'h0) ? 32'h1 :
                    apply_strb(gate_q, wdata_q, wstrb_q);
        end
        default: begin
        end
      endcase
    end
  end

  // read decode; unmapped words answer zero with an error response
  always_comb begin
    rd_word = 32'h0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `CMRT_ADDR_CTRL: rd_word = {25'h0, ctrl_q.lockout, ctrl_q.clr, ctrl_q.hold, 1'b0,
                                  ctrl_q.func};
      `CMRT_ADDR_AVG: rd_word = {22'h0, avg_q};
      `CMRT_ADDR_GATE: rd_word = gate_q;
      `CMRT_ADDR_STAT: begin
        rd_word[`CMRT_STAT_BLANK_BIT] = display_blank_q;
        rd_word[`CMRT_STAT_BUSY_BIT] = gate_busy_q;
        rd_word[`CMRT_STAT_LOCK_BIT] = mult_lock_q;
        rd_word[`CMRT_STAT_ARMED_BIT] = (wst_q != cmrt_pkg::w_arm);
        rd_word[`CMRT_STAT_ROUTE_MSB:`CMRT_STAT_ROUTE_LSB] = route_q;
        rd_word[`CMRT_STAT_DP_BIT] = display_point_en_q;
      end
      `CMRT_ADDR_DISP: rd_word = display_q;
      `CMRT_ADDR_ACCUM: rd_word = count_q;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_have_q <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `CMRT_RESP_OKAY;
    end else begin
      ar_have_q <= ar_have_d;
      s_axi_arready <= !ar_have_d && !rvalid_d;
      s_axi_rvalid <= rvalid_d;
      if (ar_have_d) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `CMRT_RESP_OKAY : `CMRT_RESP_SLVERR;
      end
    end
  end

  AST_ROUTE_ONEHOT: assert property (@(posedge aclk) disable iff (!aresetn)
    $onehot({route_q.direct_en, route_q.alt_en, !route_q.presc_en_n, route_q.mult_en}))
    else $error("routing paths not exactly one");
  AST_NEG_ALT: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_q.func == cmrt_pkg::func_width_neg) |=> (route_q.alt_en && !route_q.direct_en))
    else $error("negative width not on alternate path");
  AST_HIGH_PRESC: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_q.func == cmrt_pkg::func_freq_high) |=>
    (!route_q.presc_en_n && !route_q.direct_en && !route_q.alt_en))
    else $error("high band not through prescaler only");
  AST_EVENT_AB: assert property (@(posedge aclk) disable iff (!aresetn)
    event_a_q == event_b_q) else $error("event inputs differ");
  AST_TOT_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
    (tot && !ctrl_q.clr && !func_chg && a_rise) |=> (count_q == $past(count_q) + 32'h1))
    else $error("totalize missed an event");
  AST_TOT_FOLLOW: assert property (@(posedge aclk) disable iff (!aresetn)
    (tot && !ctrl_q.hold && !ctrl_q.clr && !func_chg) |=> (display_q == count_q))
    else $error("totalize display not following total");
  AST_TOT_FREEZE: assert property (@(posedge aclk) disable iff (!aresetn)
    (tot && ctrl_q.hold && !ctrl_q.clr && !func_chg) |=> $stable(display_q))
    else $error("frozen totalize display moved");
  AST_CLR_BLANK: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_q.clr |=> (count_q == 32'h0 && display_q == 32'h0 && display_blank_q))
    else $error("reset did not clear and blank");
  AST_HOLD_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
    (!tot && ctrl_q.hold && !ctrl_q.clr && !func_chg) |=> ($stable(count_q) && $stable(display_q)))
    else $error("hold did not stop the counter");
  AST_AVG_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
    (avg_q >= `CMRT_AVG_MIN) && (avg_q <= `CMRT_AVG_MAX)) else $error("averaging out of range");
  AST_WIDTH_ARM: assert property (@(posedge aclk) disable iff (!aresetn)
    ((ctrl_q.func == cmrt_pkg::func_width_pos || ctrl_q.func == cmrt_pkg::func_width_neg) &&
     wst_q == cmrt_pkg::w_arm) |=> (wst_q != cmrt_pkg::w_meas))
    else $error("width measured without arming");
endmodule // cmrt_top

//--- verification/cmrt_src.sv
// pulse source standing in for the conditioned trigger output
`timescale 1ns/10ps
module cmrt_src (
  input wire logic aclk,
  output logic sig
);
  // rests low between bursts, as the trigger stage idles low
  initial sig = 1'b0;
  // n pulses, each lo cycles low then hi cycles high, changed after the edge
  task automatic burst(input int n, input int hi, input int lo);
    repeat (n) begin
      repeat (lo) @(posedge aclk);
      sig <= 1'b1;
      repeat (hi) @(posedge aclk);
      sig <= 1'b0;
    end
  endtask
endmodule // cmrt_src

//--- verification/test_counter_mode_routing_totalize.sv
// self-checking bench for the counter mode routing and totalize block
`timescale 1ns/10ps
`include "cmrt_cfg.svh"
module test_counter_mode_routing_totalize;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic sig_in;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ea, eb, blank, dp, busy, lock, ea_d;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, disp;
  cmrt_pkg::cmrt_route_t route;
  int error_cnt = 0;
  int check_count = 0;
  int rises = 0;
  cmrt_src cmrt_src_i (.aclk(aclk), .sig(sig_in));
  // small top period keeps the out-of-range timeout short in simulation
  cmrt_top #(.MULT_MAX_PERIOD_CYC(20000)) cmrt_top_i (.aclk(aclk), .aresetn(aresetn),
    .sig_in(sig_in), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .route_q(route), .event_a_q(ea), .event_b_q(eb), .display_q(disp),
    .display_blank_q(blank), .display_point_en_q(dp), .gate_busy_q(busy), .mult_lock_q(lock));
  // clock and rise counter on the routed event line
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    ea_d <= ea;
    if (ea === 1'b1 && ea_d === 1'b0) rises <= rises + 1;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (awvalid || wvalid || bvalid !== 1'b1) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, 32'h0);
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [33:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (rvalid !== 1'b1) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(n, rdata, e[31:0]);
    chk("rresp", {30'h0, rresp}, {30'h0, e[33:32]});
  endtask
  task automatic t_reset;
    chk("route", route, 32'hA);
    chk("disp", disp, 32'h0);
    chk("blank", blank, 32'h1);
    rchk("avg", `CMRT_ADDR_AVG, 34'h1);
    rchk("gate", `CMRT_ADDR_GATE, {2'h0, `CMRT_GATE_RST});
    rchk("unmapped", 8'h18, {`CMRT_RESP_SLVERR, 32'h0});
  endtask
  // every function code, the two spare codes too
  task automatic t_route;
    logic [31:0] tbl = 32'hAAA6AA0A;
    for (int i = 0; i < 8; i++) begin
      axi_wr(`CMRT_ADDR_CTRL, i);
      repeat (3) @(posedge aclk);
      chk("route", route, tbl[i*4+:4]);
      chk("evt_b", eb, ea);
      chk("dp_en", dp, i != 5);
    end
  endtask
  task automatic t_total;
    axi_wr(`CMRT_ADDR_CTRL, 32'h5);
    cmrt_src_i.burst(7, 4, 4);
    repeat (10) @(posedge aclk);
    chk("total", disp, 32'h7);
    chk("busy_tot", busy, 32'h1);
    axi_wr(`CMRT_ADDR_AVG, 32'h3);
    chk("avg_ignored", disp, 32'h7);
    axi_wr(`CMRT_ADDR_CTRL, 32'h15);
    cmrt_src_i.burst(5, 4, 4);
    repeat (10) @(posedge aclk);
    chk("frozen", disp, 32'h7);
    rchk("accum", `CMRT_ADDR_ACCUM, 34'hC);
    axi_wr(`CMRT_ADDR_CTRL, 32'h5);
    repeat (3) @(posedge aclk);
    chk("released", disp, 32'hC);
    cmrt_src_i.burst(1, 4, 4);
    repeat (10) @(posedge aclk);
    chk("follows", disp, 32'hD);
    axi_wr(`CMRT_ADDR_CTRL, 32'h25);
    repeat (3) @(posedge aclk);
    chk("cleared", {blank, disp[30:0]}, 32'h80000000);
  endtask
  // twenty input edges give two prescaled rises whatever the phase
  task automatic t_presc;
    int r0;
    axi_wr(`CMRT_ADDR_CTRL, 32'h1);
    repeat (5) @(posedge aclk);
    r0 = rises;
    cmrt_src_i.burst(20, 3, 3);
    repeat (20) @(posedge aclk);
    chk("presc_rises", rises - r0, 32'h2);
  endtask
  // first pulse only arms, so two pulses must not complete a pair
  task automatic t_width;
    axi_wr(`CMRT_ADDR_AVG, 32'h7D0);
    rchk("avg_clamp", `CMRT_ADDR_AVG, 34'h3E8);
    axi_wr(`CMRT_ADDR_AVG, 32'h2);
    axi_wr(`CMRT_ADDR_CTRL, 32'h3);
    cmrt_src_i.burst(2, 10, 10);
    repeat (20) @(posedge aclk);
    chk("armed", disp, 32'h0);
    cmrt_src_i.burst(1, 10, 10);
    repeat (20) @(posedge aclk);
    chk("width_sum", disp, 32'h14);
    // hold outside totalize: a full pulse must leave count and display alone
    axi_wr(`CMRT_ADDR_CTRL, 32'h13);
    cmrt_src_i.burst(1, 10, 10);
    repeat (20) @(posedge aclk);
    chk("held", disp, 32'h14);
    chk("held_busy", busy, 32'h0);
    rchk("held_cnt", `CMRT_ADDR_ACCUM, 34'h0);
  endtask
  task automatic t_mult;
    axi_wr(`CMRT_ADDR_CTRL, 32'h0);
    cmrt_src_i.burst(4, 2500, 2500);
    repeat (5) @(posedge aclk);
    chk("lock", lock, 32'h1);
    chk("route_mult", route, 32'h3);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // main sequence after twenty cycles of reset
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_route;
    t_total;
    t_presc;
    t_width;
    t_mult;
    wrap_up;
  end
  // watchdog, about three times the expected run
  initial begin
    repeat (60000) @(posedge aclk);
    error_cnt++;
    wrap_up;
  end
endmodule // test_counter_mode_routing_totalize
